//--- dv/cmb_eng_model.sv
`timescale 1ns/1ps

// ======================================================================
// protocol engine stand-in: offers frames, pulses tx events, reads ram
module cmb_eng_model (
  input  wire logic                 pclk,
  output cmb_pkg::cmb_rx_msg_type   rx_msg,
  output logic                      rx_valid,
  input  wire logic                 rx_ready,
  output cmb_pkg::cmb_tx_event_type tx_ev,
  output logic [7:0]                eng_rd_addr,
  input  wire logic [15:0]          eng_rd_data,
  input  wire logic                 eng_rd_grant
);
  // quiet engine at time zero
  initial
  begin
    rx_valid = 1'b0;
    rx_msg = '0;
    tx_ev = '0;
    eng_rd_addr = 8'h00;
  end

  // frame held until taken; fields invert after release so stale data never matches
  task automatic send(input cmb_pkg::cmb_rx_msg_type m);
    @(posedge pclk);
    rx_valid <= 1'b1;
    rx_msg <= m;
    @(posedge pclk);
    while (rx_ready !== 1'b1)
      @(posedge pclk);
    rx_valid <= 1'b0;
    rx_msg <= ~m;
  endtask

  // one-cycle event pulse
  task automatic pulse(input cmb_pkg::cmb_tx_event_type e);
    @(posedge pclk);
    tx_ev <= e;
    @(posedge pclk);
    tx_ev <= '0;
  endtask

  // port b read: grant seen at the address edge, data one edge later
  task automatic rd(input logic [7:0] a, output logic [15:0] d, output logic g);
    @(posedge pclk);
    eng_rd_addr <= a;
    @(posedge pclk);
    g = eng_rd_grant;
    @(posedge pclk);
    d = eng_rd_data;
    eng_rd_addr <= ~a;
  endtask
endmodule

//--- dv/testbench.sv
`timescale 1ns/1ps

`define CHK(got, exp) \
  begin \
    checked++; \
    if ((got) !== (exp)) \
    begin \
      mismatches++; \
      $display("ERROR %0t: got %h expected %h", $time, got, exp); \
    end \
  end

module testbench;
  // ====================================================================
  // signals
  logic                      pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic                      rx_valid, rx_ready, tx_sel_valid, eng_rd_grant, acc_match, err;
  logic [11:0]               paddr;
  logic [31:0]               pwdata, prdata, rd;
  logic [7:0]                send_pending, eng_rd_addr;
  logic [2:0]                tx_sel_buf;
  logic [15:0]               eng_rd_data, acc_filter_eid, acc_msg_eid;
  logic [1:0]                acc_mask_sel;
  cmb_pkg::cmb_rx_msg_type   rx_msg, msg;
  cmb_pkg::cmb_tx_event_type tx_ev;
  int                        mismatches, checked, cycles;

  cmb_top u_dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hf), .prdata,
    .pready, .pslverr, .rx_valid, .rx_msg, .rx_ready, .tx_ev, .send_pending, .tx_sel_valid,
    .tx_sel_buf, .eng_rd_addr, .eng_rd_data, .eng_rd_grant, .acc_mask_sel, .acc_filter_eid,
    .acc_msg_eid, .acc_match);
  cmb_eng_model u_eng (.pclk, .rx_msg, .rx_valid, .rx_ready, .tx_ev, .eng_rd_addr, .eng_rd_data,
    .eng_rd_grant);

  // 200 MHz clock
  always #2.5 pclk = ~pclk;

  // hang guard: the whole run needs well under this many cycles
  always @(posedge pclk)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      mismatches++;
      final_report();
    end
  end

  // ====================================================================
  // bus helpers
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1)
      @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rchk(input logic [11:0] a, input logic [31:0] e);
    apb(1'b0, a, 32'h0);
    `CHK(rd, e)
  endtask

  task automatic acc(input logic [1:0] s, input logic [15:0] f, input logic [15:0] m, input logic e);
    @(posedge pclk);
    acc_mask_sel <= s;
    acc_filter_eid <= f;
    acc_msg_eid <= m;
    repeat (2) @(posedge pclk);
    `CHK(acc_match, e)
  endtask

  // ====================================================================
  // scenarios
  task automatic t_reset();
    rchk(12'h010, 32'h0);
    rchk(12'h014, 32'h0);
    rchk(12'h018, 32'h0);
    rchk(12'h01c, 32'h0);
    rchk(12'h024, 32'h0);
    apb(1'b0, 12'h030, 32'h0);
    `CHK({err, rd}, 33'h1_0000_0000)
  endtask

  task automatic t_mask();
    apb(1'b1, 12'h000, 32'h0000_00ff);
    apb(1'b1, 12'h008, 32'h0000_ffff);
    rchk(12'h000, 32'h0000_00ff);
    acc(2'h0, 16'h12ab, 16'h34ab, 1'b1);
    acc(2'h0, 16'h12ab, 16'h34ac, 1'b0);
    acc(2'h2, 16'h1234, 16'h1235, 1'b0);
    acc(2'h2, 16'h1234, 16'h1234, 1'b1);
    acc(2'h3, 16'h1234, 16'h1234, 1'b0);
  endtask

  // store into buffer 17, then walk its eight words
  task automatic t_rx();
    logic [15:0] w [8];
    logic [15:0] d;
    logic        g;
    msg = {5'd17, 5'h15, 11'h5a3, 1'b1, 1'b1, 18'h2b3c5, 1'b1, 4'h8, 64'h8877_6655_4433_2211};
    w[0] = {3'h0, msg.sid, msg.srr, msg.ide};
    w[1] = {4'h0, msg.eid[17:6]};
    w[2] = {msg.eid[5:0], msg.rtr & msg.ide, 1'b0, 3'h0, 1'b0, msg.dlc};
    for (int i = 0; i < 4; i++)
      w[3 + i] = msg.data[16 * i +: 16];
    w[7] = {3'h0, msg.hit, 8'h00};
    u_eng.send(msg);
    rd = 32'h0;
    for (int i = 0; i < 20 && rd[1] !== 1'b1; i++)
      apb(1'b0, 12'h014, 32'h0);
    `CHK(rd, 32'h0000_0002)
    for (int i = 0; i < 8; i++)
    begin
      apb(1'b0, {2'h1, 5'd17, 3'(i), 2'h0}, 32'h0);
      `CHK(rd[15:0], w[i])
    end
    u_eng.rd({5'd17, 3'h7}, d, g);
    `CHK({g, d}, {1'b1, w[7]})
    apb(1'b1, {2'h1, 5'd5, 3'h3, 2'h0}, 32'h0000_a55a);
    rchk({2'h1, 5'd5, 3'h3, 2'h0}, 32'h0000_a55a);
  endtask

  // second frame to a full buffer; ones written must not set, zeros clear
  task automatic t_ovf();
    u_eng.send(msg);
    rchk(12'h01c, 32'h0000_0002);
    rchk(12'h014, 32'h0000_0002);
    apb(1'b1, 12'h014, 32'h0000_ffff);
    apb(1'b1, 12'h01c, 32'h0000_ffff);
    rchk(12'h014, 32'h0000_0002);
    rchk(12'h01c, 32'h0000_0002);
    apb(1'b1, 12'h014, 32'h0000_fffd);
    apb(1'b1, 12'h01c, 32'h0000_fffd);
    rchk(12'h014, 32'h0);
    rchk(12'h01c, 32'h0);
    msg.buf_idx = 5'd3;
    u_eng.send(msg);
    repeat (9) @(posedge pclk);
    rchk(12'h010, 32'h0000_0008);
  endtask

  // buffers 2 and 3 share one control word
  task automatic t_tx();
    cmb_pkg::cmb_tx_event_type e;
    apb(1'b1, 12'h024, 32'h0000_8b89);
    repeat (2) @(posedge pclk);
    `CHK(send_pending, 8'h0c)
    `CHK({tx_sel_valid, tx_sel_buf}, 4'hb)
    e = '0;
    e.done[3] = 1'b1;
    u_eng.pulse(e);
    rchk(12'h024, 32'h0000_8389);
    e = '0;
    e.aborted[2] = 1'b1;
    e.arb_lost[2] = 1'b1;
    e.error[2] = 1'b1;
    u_eng.pulse(e);
    rchk(12'h024, 32'h0000_83f1);
    apb(1'b1, 12'h024, 32'h0000_83f9);
    rchk(12'h024, 32'h0000_8389);
    apb(1'b1, 12'h024, 32'h0000_8781);
    apb(1'b1, 12'h020, 32'h0000_0800);
    e = '0;
    e.remote_hit = 8'h0c;
    u_eng.pulse(e);
    @(posedge pclk);
    `CHK(send_pending, 8'h08)
    rchk(12'h024, 32'h0000_8f81);
  endtask

  task automatic final_report();
    $display("checked %0d mismatches %0d", checked, mismatches);
    if (mismatches == 0 && checked > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // ====================================================================
  // main sequence
  initial
  begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {acc_mask_sel, acc_filter_eid, acc_msg_eid} = '0;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_mask();
    t_rx();
    t_ovf();
    t_tx();
    final_report();
  end
endmodule

//--- rtl/cmb_msg_ram.sv
`timescale 1ns/1ps

// =====================================================================
// two-port message buffer ram, registered read data on both ports
module cmb_msg_ram #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 256,
  parameter int AW    = 8
) (
  input  wire logic             clk,
  input  wire logic             a_we,
  input  wire logic [AW-1:0]    a_addr,
  input  wire logic [WIDTH-1:0] a_wdata,
  output logic      [WIDTH-1:0] a_rdata,
  input  wire logic             b_we,
  input  wire logic [AW-1:0]    b_addr,
  input  wire logic [WIDTH-1:0] b_wdata,
  output logic      [WIDTH-1:0] b_rdata
);

  logic [WIDTH-1:0] mem [DEPTH];

  // both ports read before write; same-address collisions favour port b
  always_ff @(posedge clk)
  begin
    if (a_we)
      mem[a_addr] <= a_wdata;
    if (b_we)
      mem[b_addr] <= b_wdata;
    a_rdata <= mem[a_addr];
    b_rdata <= mem[b_addr];
  end

endmodule

//--- rtl/cmb_params.svh
`ifndef CMB_PARAMS_SVH
`define CMB_PARAMS_SVH

// =====================================================================
// sizes
`define CMB_NUM_RXBUF     32
`define CMB_NUM_TXBUF     8
`define CMB_NUM_MASK      3
`define CMB_RAM_DEPTH     256
`define CMB_RAM_AW        8
`define CMB_WORD_W        16
`define CMB_LAST_WORD     3'h7

// =====================================================================
// register word indices; byte address is four times the index
`define CMB_IDX_MASK0     4'h0
`define CMB_IDX_MASK1     4'h1
`define CMB_IDX_MASK2     4'h2
`define CMB_IDX_FULL_LO   4'h4
`define CMB_IDX_FULL_HI   4'h5
`define CMB_IDX_OVF_LO    4'h6
`define CMB_IDX_OVF_HI    4'h7
`define CMB_IDX_TRCON0    4'h8
`define CMB_IDX_TRCON1    4'h9
`define CMB_IDX_TRCON3    4'hb
`define CMB_REG_PAGE      6'h00
`define CMB_RAM_PAGE      2'h1

// =====================================================================
// reset values
`define CMB_RST_FLAGS     32'h0000_0000
`define CMB_RST_MASK      16'h0000
`define CMB_RST_CTRL      8'h00

// =====================================================================
// control byte fields
`define CMB_B_DIR         7
`define CMB_B_ABT         6
`define CMB_B_ARB         5
`define CMB_B_ERR         4
`define CMB_B_REQ         3
`define CMB_B_RTREN       2
`define CMB_SW_BITS       8'h8f
`define CMB_PRI_NONE      3'h0

// =====================================================================
// message buffer words and fields
`define CMB_W_STD         3'h0
`define CMB_W_EXT         3'h1
`define CMB_W_CTL         3'h2
`define CMB_W_D01         3'h3
`define CMB_W_D23         3'h4
`define CMB_W_D45         3'h5
`define CMB_W_D67         3'h6
`define CMB_W_HIT         3'h7
`define CMB_W2_RTR        9
`define CMB_W2_RSV1       8
`define CMB_W2_RSV0       4
`define CMB_W7_HIT_LO     8
`define CMB_MSEL_RSVD     2'h3

`endif

//--- rtl/cmb_pkg.sv
package cmb_pkg;

  // =====================================================================
  // receive store sequencer states
  typedef enum logic {CMB_IDLE, CMB_WRITE} cmb_fsm_type;

  // =====================================================================
  // a received message handed over by the protocol engine
  typedef struct packed {
    logic [4:0]  buf_idx;
    logic [4:0]  hit;
    logic [10:0] sid;
    logic        srr;
    logic        ide;
    logic [17:0] eid;
    logic        rtr;
    logic [3:0]  dlc;
    logic [63:0] data;
  } cmb_rx_msg_type;

  // per transmit buffer event pulses from the protocol engine
  typedef struct packed {
    logic [7:0] done;
    logic [7:0] aborted;
    logic [7:0] arb_lost;
    logic [7:0] error;
    logic [7:0] remote_hit;
  } cmb_tx_event_type;

  // =====================================================================
  // all register state of the block; message contents stay in the ram
  typedef struct packed {
    logic [2:0][15:0] mask;
    logic [31:0]      full;
    logic [31:0]      ovf;
    logic [7:0][7:0]  ctrl;
    cmb_fsm_type      fsm;
    logic [2:0]       cnt;
    cmb_rx_msg_type   msg;
    logic [15:0]      rd_data;
    logic             rd_ram;
    logic             tx_sel_valid;
    logic [2:0]       tx_sel_buf;
    logic             acc_match;
  } cmb_core_type;

endpackage

//--- rtl/cmb_top.sv
`timescale 1ns/1ps
`include "cmb_params.svh"

// Notes on behaviour
// RULE_01: mask bit one compares that identifier bit; zero makes it don't care.
// RULE_02: storing a message into a receive buffer sets its full flag.
// RULE_03: software clears the full flag after consuming the buffer.
// RULE_04: full and overflow bits clear on written zero; written one changes nothing.
// RULE_05: storing into an already full buffer sets its overflow flag instead.
// RULE_06: software clears overflow flags; hardware never clears them.
// RULE_07: control word low byte serves even buffer, high byte next odd.
// RULE_08: word 0 holds standard id in 12-2, srr bit 1, ide bit 0.
// RULE_09: rtr is word 2 bit 9, meaningful only for extended frames.
// RULE_10: extended id 17:6 in word 1 bits 11-0, 5:0 in word 2 15-10.
// RULE_11: length code in word 2 bits 3-0; reserved bits 8 and 4 zero.
// RULE_12: words 3-6 carry payload, even byte low, odd byte high.
// RULE_13: message contents live in shared ram, not in registers.
// RULE_14: software chooses buffer area and writes contents straight into ram.
// RULE_15: receive stores write filter hit code into word 7 bits 12-8.
// RULE_16: direction bit set means transmit buffer, clear means receive.
// RULE_17: send request set by software, cleared on success; new request clears status.
// RULE_18: remote request sets send request if enabled; priority three is highest.
module cmb_top (
  input  wire logic                      pclk,
  input  wire logic                      presetn,
  input  wire logic                      psel,
  input  wire logic                      penable,
  input  wire logic                      pwrite,
  input  wire logic [11:0]               paddr,
  input  wire logic [31:0]               pwdata,
  input  wire logic [3:0]                pstrb,
  output logic      [31:0]               prdata,
  output logic                           pready,
  output logic                           pslverr,
  input  wire logic                      rx_valid,
  input  wire cmb_pkg::cmb_rx_msg_type   rx_msg,
  output logic                           rx_ready,
  input  wire cmb_pkg::cmb_tx_event_type tx_ev,
  output logic      [7:0]                send_pending,
  output logic                           tx_sel_valid,
  output logic      [2:0]                tx_sel_buf,
  input  wire logic [7:0]                eng_rd_addr,
  output logic      [15:0]               eng_rd_data,
  output logic                           eng_rd_grant,
  input  wire logic [1:0]                acc_mask_sel,
  input  wire logic [15:0]               acc_filter_eid,
  input  wire logic [15:0]               acc_msg_eid,
  output logic                           acc_match
);

  // =====================================================================
  // state and decode
  cmb_pkg::cmb_core_type s_ff;
  cmb_pkg::cmb_core_type nxt_s;

  logic        setup;
  logic        wr_en;
  logic [3:0]  reg_idx;
  logic        reg_hit;
  logic        ram_hit;
  logic [15:0] lane_mask;
  logic        ram_we_b;
  logic [7:0]  ram_addr_b;
  logic [15:0] ram_wdata_b;
  logic [15:0] ram_rdata_a;
  logic        store_ok;
  logic        store_ovf;
  logic [31:0] sw_clr_full;
  logic [31:0] sw_clr_ovf;
  logic [31:0] hw_set_full;
  logic [31:0] hw_set_ovf;

  // apb has no wait states: every access completes in its first access cycle
  assign setup     = psel & ~penable;
  assign wr_en     = psel & penable & pwrite;
  assign reg_idx   = paddr[5:2];
  assign reg_hit   = (paddr[11:6] == `CMB_REG_PAGE) && (reg_idx <= `CMB_IDX_TRCON3) && (reg_idx != 4'h3);
  assign ram_hit   = (paddr[11:10] == `CMB_RAM_PAGE);
  assign lane_mask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
  assign pready    = 1'b1;
  assign pslverr   = psel & penable & ~(reg_hit | ram_hit);

  // =====================================================================
  // message word builder, unused bits and reserved bits written as zero
  function automatic logic [15:0] msg_word(input cmb_pkg::cmb_rx_msg_type m, input logic [2:0] w);
    logic [15:0] r;
    r = 16'h0000;
    unique case (w)
      `CMB_W_STD: r = {3'h0, m.sid, m.srr, m.ide};                  // RULE_08
      `CMB_W_EXT: r = {4'h0, m.eid[17:6]};                          // RULE_10
      `CMB_W_CTL: r = {m.eid[5:0], m.rtr & m.ide, 1'b0, 3'h0, 1'b0, m.dlc}; // RULE_09 RULE_10 RULE_11
      `CMB_W_D01: r = m.data[15:0];                                 // RULE_12
      `CMB_W_D23: r = m.data[31:16];
      `CMB_W_D45: r = m.data[47:32];
      `CMB_W_D67: r = m.data[63:48];
      `CMB_W_HIT: r = {3'h0, m.hit, 8'h00};                         // RULE_15
    endcase
    return r;
  endfunction

  // =====================================================================
  // receive store handshake
  assign rx_ready  = (s_ff.fsm == cmb_pkg::CMB_IDLE);
  assign store_ovf = rx_valid & rx_ready & s_ff.full[rx_msg.buf_idx];
  assign store_ok  = rx_valid & rx_ready & ~s_ff.full[rx_msg.buf_idx];

  // ram port b: store sequencer owns it, engine reads when idle
  assign ram_we_b     = (s_ff.fsm == cmb_pkg::CMB_WRITE);                   // RULE_13
  assign ram_addr_b   = ram_we_b ? {s_ff.msg.buf_idx, s_ff.cnt} : eng_rd_addr;
  assign ram_wdata_b  = msg_word(s_ff.msg, s_ff.cnt);
  assign eng_rd_grant = ~ram_we_b;

  // flag set and clear terms; set beats clear in the same cycle
  always_comb
  begin
    sw_clr_full = 32'h0;
    sw_clr_ovf  = 32'h0;
    hw_set_full = 32'h0;
    hw_set_ovf  = 32'h0;
    if (wr_en && reg_hit)
    begin
      if (reg_idx == `CMB_IDX_FULL_LO) sw_clr_full[15:0]  = ~pwdata[15:0] & lane_mask; // RULE_04
      if (reg_idx == `CMB_IDX_FULL_HI) sw_clr_full[31:16] = ~pwdata[15:0] & lane_mask;
      if (reg_idx == `CMB_IDX_OVF_LO)  sw_clr_ovf[15:0]   = ~pwdata[15:0] & lane_mask;
      if (reg_idx == `CMB_IDX_OVF_HI)  sw_clr_ovf[31:16]  = ~pwdata[15:0] & lane_mask;
    end
    if (ram_we_b && (s_ff.cnt == `CMB_LAST_WORD))
      hw_set_full[s_ff.msg.buf_idx] = 1'b1;                         // RULE_02
    if (store_ovf)
      hw_set_ovf[rx_msg.buf_idx] = 1'b1;                            // RULE_05
  end

  // =====================================================================
  // next state
  always_comb
  begin
    logic [7:0] wbyte;
    logic       lane_en;
    logic [2:0] best_pri;
    nxt_s    = s_ff;
    wbyte    = 8'h00;
    lane_en  = 1'b0;
    best_pri = `CMB_PRI_NONE;

    // flags: only hardware sets, only software clears
    nxt_s.full = (s_ff.full & ~sw_clr_full) | hw_set_full;
    nxt_s.ovf  = (s_ff.ovf & ~sw_clr_ovf) | hw_set_ovf;             // RULE_06

    // acceptance masks, byte lanes honoured
    for (int m = 0; m < `CMB_NUM_MASK; m++)
      if (wr_en && reg_hit && (reg_idx == 4'(m)))
        nxt_s.mask[m] = (s_ff.mask[m] & ~lane_mask) | (pwdata[15:0] & lane_mask);

    // per buffer control byte, even buffer low lane, odd buffer high lane
    for (int i = 0; i < `CMB_NUM_TXBUF; i++)
    begin
      wbyte   = pwdata[8*(i%2) +: 8];                               // RULE_07
      lane_en = wr_en && reg_hit && pstrb[i%2] && (reg_idx == 4'(`CMB_IDX_TRCON0 + i/2));
      // success or abort ends the request
      if (tx_ev.done[i] || tx_ev.aborted[i])
        nxt_s.ctrl[i][`CMB_B_REQ] = 1'b0;                           // RULE_17
      if (lane_en)
      begin
        nxt_s.ctrl[i] = (nxt_s.ctrl[i] & ~`CMB_SW_BITS) | (wbyte & `CMB_SW_BITS); // RULE_16
        if (wbyte[`CMB_B_REQ] && !s_ff.ctrl[i][`CMB_B_REQ])
        begin
          nxt_s.ctrl[i][`CMB_B_ABT] = 1'b0;                         // RULE_17
          nxt_s.ctrl[i][`CMB_B_ARB] = 1'b0;
          nxt_s.ctrl[i][`CMB_B_ERR] = 1'b0;
        end
      end
      // remote request answered automatically by a transmit buffer
      if (tx_ev.remote_hit[i] && s_ff.ctrl[i][`CMB_B_RTREN] && s_ff.ctrl[i][`CMB_B_DIR])
        nxt_s.ctrl[i][`CMB_B_REQ] = 1'b1;                           // RULE_18
      // engine status wins over a clearing write in the same cycle
      if (tx_ev.aborted[i])  nxt_s.ctrl[i][`CMB_B_ABT] = 1'b1;
      if (tx_ev.arb_lost[i]) nxt_s.ctrl[i][`CMB_B_ARB] = 1'b1;
      if (tx_ev.error[i])    nxt_s.ctrl[i][`CMB_B_ERR] = 1'b1;
    end

    // pick highest priority pending transmit buffer, lowest index on a tie
    nxt_s.tx_sel_valid = 1'b0;
    nxt_s.tx_sel_buf   = 3'h0;
    for (int i = `CMB_NUM_TXBUF - 1; i >= 0; i--)
      if (s_ff.ctrl[i][`CMB_B_DIR] && s_ff.ctrl[i][`CMB_B_REQ] &&
          ({1'b1, s_ff.ctrl[i][1:0]} >= best_pri))
      begin
        best_pri           = {1'b1, s_ff.ctrl[i][1:0]};            // RULE_18
        nxt_s.tx_sel_valid = 1'b1;
        nxt_s.tx_sel_buf   = 3'(i);
      end

    // extended id compare through the selected mask
    nxt_s.acc_match = (acc_mask_sel != `CMB_MSEL_RSVD) &&
                      (((acc_msg_eid ^ acc_filter_eid) & s_ff.mask[acc_mask_sel]) == 16'h0000); // RULE_01

    // receive store sequencer: eight words then full flag
    unique case (s_ff.fsm)
      cmb_pkg::CMB_IDLE:
        if (store_ok)
        begin
          nxt_s.msg = rx_msg;
          nxt_s.cnt = `CMB_W_STD;
          nxt_s.fsm = cmb_pkg::CMB_WRITE;
        end
      cmb_pkg::CMB_WRITE:
      begin
        nxt_s.cnt = s_ff.cnt + 3'h1;
        if (s_ff.cnt == `CMB_LAST_WORD)
          nxt_s.fsm = cmb_pkg::CMB_IDLE;
      end
    endcase

    // read data captured in the setup cycle
    if (setup)
    begin
      nxt_s.rd_ram = ram_hit;
      unique case (reg_idx)
        `CMB_IDX_MASK0, `CMB_IDX_MASK1, `CMB_IDX_MASK2:
          nxt_s.rd_data = s_ff.mask[reg_idx[1:0]];
        `CMB_IDX_FULL_LO: nxt_s.rd_data = s_ff.full[15:0];
        `CMB_IDX_FULL_HI: nxt_s.rd_data = s_ff.full[31:16];
        `CMB_IDX_OVF_LO:  nxt_s.rd_data = s_ff.ovf[15:0];
        `CMB_IDX_OVF_HI:  nxt_s.rd_data = s_ff.ovf[31:16];
        `CMB_IDX_TRCON0, 4'h9, 4'ha, `CMB_IDX_TRCON3:
          nxt_s.rd_data = {s_ff.ctrl[{reg_idx[1:0], 1'b1}], s_ff.ctrl[{reg_idx[1:0], 1'b0}]};
        default:          nxt_s.rd_data = 16'h0000;
      endcase
      if (!reg_hit)
        nxt_s.rd_data = 16'h0000;
    end
  end

  // =====================================================================
  // state register
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s_ff              <= '0;
      s_ff.mask         <= {`CMB_NUM_MASK{`CMB_RST_MASK}};
      s_ff.full         <= `CMB_RST_FLAGS;
      s_ff.ovf          <= `CMB_RST_FLAGS;
      s_ff.ctrl         <= {`CMB_NUM_TXBUF{`CMB_RST_CTRL}};
      s_ff.fsm          <= cmb_pkg::CMB_IDLE;
    end
    else
      s_ff <= nxt_s;
  end

  // =====================================================================
  // message ram: port a for software, port b for the store sequencer and engine reads
  cmb_msg_ram #(
    .WIDTH (`CMB_WORD_W),
    .DEPTH (`CMB_RAM_DEPTH),
    .AW    (`CMB_RAM_AW)
  ) u_ram (
    .clk     (pclk),
    .a_we    (wr_en & ram_hit & pstrb[0] & pstrb[1]),               // RULE_14
    .a_addr  (paddr[9:2]),
    .a_wdata (pwdata[15:0]),
    .a_rdata (ram_rdata_a),
    .b_we    (ram_we_b),
    .b_addr  (ram_addr_b),
    .b_wdata (ram_wdata_b),
    .b_rdata (eng_rd_data)
  );

  // =====================================================================
  // outputs
  assign prdata       = {16'h0000, s_ff.rd_ram ? ram_rdata_a : s_ff.rd_data};
  assign tx_sel_valid = s_ff.tx_sel_valid;
  assign tx_sel_buf   = s_ff.tx_sel_buf;
  assign acc_match    = s_ff.acc_match;
  always_comb
  begin
    for (int i = 0; i < `CMB_NUM_TXBUF; i++)
      send_pending[i] = s_ff.ctrl[i][`CMB_B_DIR] & s_ff.ctrl[i][`CMB_B_REQ];
  end

  // =====================================================================
  // checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic        chk_full_hi_wr;
  logic [15:0] chk_full_hi_exp;
  assign chk_full_hi_wr  = wr_en && reg_hit && (reg_idx == `CMB_IDX_FULL_HI) && !ram_we_b;
  assign chk_full_hi_exp = s_ff.full[31:16] & (pwdata[15:0] | ~lane_mask);

  sequence accept_free_s;
    rx_valid && rx_ready && !s_ff.full[rx_msg.buf_idx];
  endsequence

  sequence eight_words_s;
    ram_we_b [*8] ##1 !ram_we_b;
  endsequence

  ovf_on_full_a: assert property (store_ovf |=> s_ff.ovf[$past(rx_msg.buf_idx)]) // RULE_05
    else $error("overflow flag not set on store into full buffer");

  full_after_store_a: assert property (accept_free_s ##1 eight_words_s |-> s_ff.full[$past(s_ff.msg.buf_idx)]) // RULE_02
    else $error("full flag not set after message stored");

  store_length_a: assert property (accept_free_s |=> eight_words_s) // RULE_13
    else $error("message store did not write exactly eight words");

  write_one_keeps_a: assert property (chk_full_hi_wr |=> s_ff.full[31:16] == $past(chk_full_hi_exp)) // RULE_04
    else $error("full flag write did not clear-on-zero only");

  hit_code_word_a: assert property (ram_we_b && s_ff.cnt == `CMB_W_HIT |-> // RULE_15
      ram_wdata_b[`CMB_W7_HIT_LO +: 5] == s_ff.msg.hit)
    else $error("filter hit code missing from word 7");

  reserved_zero_a: assert property (ram_we_b && s_ff.cnt == `CMB_W_CTL |-> // RULE_11
      !ram_wdata_b[`CMB_W2_RSV1] && !ram_wdata_b[`CMB_W2_RSV0] && ram_wdata_b[3:0] == s_ff.msg.dlc)
    else $error("word 2 reserved bits or length code wrong");

  done_clears_req_a: assert property (tx_ev.done[3] && !(wr_en && reg_hit && reg_idx == `CMB_IDX_TRCON1) && // RULE_17
      !tx_ev.remote_hit[3] |=> !s_ff.ctrl[3][`CMB_B_REQ])
    else $error("send request not cleared after success");

  auto_remote_a: assert property (tx_ev.remote_hit[3] && s_ff.ctrl[3][`CMB_B_RTREN] && s_ff.ctrl[3][`CMB_B_DIR] // RULE_18
      |=> s_ff.ctrl[3][`CMB_B_REQ] ##1 send_pending[3])
    else $error("remote request did not raise send request");

  new_req_clears_a: assert property (wr_en && reg_hit && reg_idx == `CMB_IDX_TRCON1 && pstrb[0] && // RULE_17
      pwdata[`CMB_B_REQ] && !s_ff.ctrl[2][`CMB_B_REQ] && !tx_ev.error[2] && !tx_ev.aborted[2] &&
      !tx_ev.arb_lost[2] |=> s_ff.ctrl[2][6:4] == 3'h0)
    else $error("status bits not cleared by new request");

  // reset released at an edge leaves the match register at zero one cycle longer
  mask_match_a: assert property (presetn && acc_mask_sel == 2'h0 && s_ff.mask[0] == 16'h0000 && // RULE_01
      $stable(s_ff.mask[0])
      |=> acc_match)
    else $error("all-zero mask did not match every identifier");

endmodule
